/* core/csplk_pkg.sv */
package csplk_pkg;
  localparam int CLK_MHZ = 100;
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG6 = 8'h06;
  localparam logic [7:0] ADDR_WDCTL = 8'h10;
  localparam logic [7:0] ADDR_SEC = 8'h11;
  localparam logic [7:0] ADDR_STAT = 8'h12;
  localparam logic [7:0] ADDR_IRQ = 8'h13;
  localparam int CFG0_CONV_BIT = 7;
  localparam int CFG6_LOWDUTY_BIT = 5;
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic [7:0] CFG6_RST = 8'h00;
  localparam logic [1:0] WD_CLEAR_CODE = 2'h1;
  localparam logic [3:0] MODE_OTG_A = 4'h9;
  localparam logic [3:0] MODE_OTG_B = 4'ha;
  localparam logic [3:0] DTL_WATCHDOG = 4'hb;
  localparam logic [3:0] DTL_THERMAL = 4'ha;
  localparam int US_RETRY = 468000;
  localparam int US_ON = 52000;
  localparam int US_OFF = 416000;
  localparam int US_ON_LOW = 1670;
  localparam int US_OFF_LOW = 104000;
  localparam int US_WATCHDOG = 80000000;
  localparam int NS_WAIT_EN = 100000;
  localparam int NS_LOW = 2000;
  localparam int NS_HIGH = 2000;
  localparam int NS_STOP = 100000;
  localparam int NS_OFF = 200000;
  localparam int TICK_CYC = CLK_MHZ;
  localparam int WAIT_CYC = NS_WAIT_EN / 10;
  localparam int LOW_CYC = NS_LOW / 10;
  localparam int HIGH_CYC = NS_HIGH / 10;
  localparam int STOP_CYC = NS_STOP / 10;
  localparam int OFF_CYC = NS_OFF / 10;
  localparam int STAGGER_CYC = WAIT_CYC + 64 * (LOW_CYC + HIGH_CYC) + STOP_CYC;
  typedef enum logic [2:0] {CSPLK_IDLE, CSPLK_WAIT, CSPLK_LOW, CSPLK_HIGH,
    CSPLK_STOP, CSPLK_OFF} csplk_swi_t;
endpackage

/* core/csplk_top.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module csplk_top import csplk_pkg::*; #(
  parameter int WD_US = US_WATCHDOG,
  parameter int ON_US = US_ON,
  parameter int OFF_US = US_OFF,
  parameter int RETRY_US = ON_US + OFF_US,
  parameter int ON_LOW_US = US_ON_LOW,
  parameter int OFF_LOW_US = OFF_US / 4,
  parameter int STAGGER = STAGGER_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [2:0] i_chg_phase,
  input wire logic i_temp_fault,
  input wire logic i_otg_overload,
  input wire logic i_sense_sel,
  input wire logic [5:0] i_max_charge,
  input wire logic [1:0] i_sec_fault,
  output logic o_charger_on,
  output logic o_charger_irq,
  output logic o_boost_fault_irq,
  output logic o_sec_fault_irq,
  output logic o_reverse_boost,
  output logic o_outward_switch,
  output logic o_otg_current_limit_field_high,
  output logic o_ext_sense,
  output logic o_pulse_line_a,
  output logic o_pulse_line_b
);
  // Phase codes: 0 idle, 1 prequal, 2 cc, 3 cv, 4 topoff, 5 done, 6 timer fault.
  localparam int WD_TICKS = WD_US;
  initial begin
    if (WD_US < 2 || ON_LOW_US < 2 || STAGGER < 1 || OFF_LOW_US < 1 || RETRY_US < 1) begin
      $error("csplk_top: bad timing parameter");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cfg0_reg;
  logic [7:0] cfg6_reg;
  logic wd_en_reg;
  logic [5:0] sec_cc_reg;
  logic auto_dis_reg;
  logic [3:0] detail_reg;
  logic charger_ok_flag_reg;
  logic boost_ok_reg;
  logic [3:0] boost_dtl_reg;
  logic wd_expired_reg;
  logic thermal_reg;
  logic [6:0] tick_cnt_reg;
  logic tick;
  logic [31:0] wd_cnt_reg;
  logic wd_clear;
  logic [31:0] otg_cnt_reg;
  logic otg_latched_reg;
  logic otg_on_phase_reg;
  logic otg_retried_reg;
  logic wd_fire;
  logic [1:0] sec_irq_reg;
  logic reverse_mode;
  logic sec_enable;
  logic [5:0] sec_cmd;
  logic [3:0] mode;

  assign mode = cfg0_reg[3:0];
  assign wd_clear = i_wr && i_addr == ADDR_WDCTL && i_wdata[1:0] == WD_CLEAR_CODE;
  assign tick = tick_cnt_reg == 7'(TICK_CYC - 1);
  // Watchdog period has run out while the charger is in a supervised phase.
  assign wd_fire = wd_en_reg && wd_cnt_reg >= 32'(WD_TICKS) && i_chg_phase != 3'h0;
  assign reverse_mode = cfg0_reg[CFG0_CONV_BIT] && (mode == MODE_OTG_A || mode == MODE_OTG_B);
  assign sec_enable = (i_chg_phase == 3'h2 || i_chg_phase == 3'h3) && !thermal_reg &&
    !wd_expired_reg;
  assign sec_cmd = (auto_dis_reg || sec_cc_reg < i_max_charge) ? sec_cc_reg : i_max_charge;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cfg0_reg <= CFG0_RST;
      cfg6_reg <= CFG6_RST;
      wd_en_reg <= 1'b0;
      sec_cc_reg <= 6'h00;
      auto_dis_reg <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_CFG0: cfg0_reg <= i_wdata;
        ADDR_CFG6: cfg6_reg <= i_wdata;
        ADDR_WDCTL: wd_en_reg <= i_wdata[7];
        ADDR_SEC: begin
          sec_cc_reg <= i_wdata[5:0];
          auto_dis_reg <= i_wdata[7];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CFG0: o_rdata <= cfg0_reg;
        ADDR_CFG6: o_rdata <= cfg6_reg;
        ADDR_WDCTL: o_rdata <= {wd_en_reg, 6'h00, wd_expired_reg};
        ADDR_SEC: o_rdata <= {auto_dis_reg, 1'b0, sec_cc_reg};
        ADDR_STAT: o_rdata <= {charger_ok_flag_reg, boost_ok_reg, thermal_reg, 1'b0, detail_reg};
        ADDR_IRQ: o_rdata <= {2'h0, sec_irq_reg, boost_dtl_reg};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || tick) begin
      tick_cnt_reg <= 7'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || wd_clear || !wd_en_reg) begin
      wd_cnt_reg <= 32'h0;
    end else if (tick && !thermal_reg && !wd_expired_reg) begin
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wd_expired_reg <= 1'b0;
    end else if (wd_clear) begin
      wd_expired_reg <= 1'b0;
    end else if (wd_fire) begin
      wd_expired_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      thermal_reg <= 1'b0;
    end else begin
      thermal_reg <= i_temp_fault;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      detail_reg <= 4'h0;
      charger_ok_flag_reg <= 1'b1;
      o_charger_irq <= 1'b0;
    end else begin
      o_charger_irq <= (i_temp_fault && !thermal_reg) ||
        (wd_en_reg && wd_cnt_reg >= 32'(WD_TICKS) && i_chg_phase != 3'h0 && !wd_expired_reg);
      if (i_temp_fault && !thermal_reg) begin
        detail_reg <= DTL_THERMAL;
        charger_ok_flag_reg <= 1'b0;
      end else if (wd_en_reg && wd_cnt_reg >= 32'(WD_TICKS) && i_chg_phase != 3'h0) begin
        detail_reg <= DTL_WATCHDOG;
        charger_ok_flag_reg <= 1'b0;
      end else if (!thermal_reg && !wd_expired_reg) begin
        detail_reg <= {1'b0, i_chg_phase};
        charger_ok_flag_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_charger_on <= 1'b0;
      o_ext_sense <= 1'b0;
      o_otg_current_limit_field_high <= 1'b0;
      o_reverse_boost <= 1'b0;
    end else begin
      o_charger_on <= !thermal_reg && !wd_expired_reg && !wd_fire && !i_temp_fault && !reverse_mode &&
        i_chg_phase != 3'h0 && i_chg_phase != 3'h6;
      o_ext_sense <= i_sense_sel;
      o_otg_current_limit_field_high <= cfg6_reg[1];
      o_reverse_boost <= reverse_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overload latch
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !reverse_mode) begin
      otg_latched_reg <= 1'b0;
      otg_on_phase_reg <= 1'b0;
      otg_retried_reg <= 1'b0;
      otg_cnt_reg <= 32'h0;
      boost_ok_reg <= 1'b1;
      boost_dtl_reg <= 4'h0;
      o_boost_fault_irq <= 1'b0;
      o_outward_switch <= 1'b0;
    end else begin
      o_boost_fault_irq <= 1'b0;
      if (!otg_latched_reg) begin
        o_outward_switch <= !i_otg_overload;
        if (i_otg_overload) begin
          otg_latched_reg <= 1'b1;
          otg_on_phase_reg <= 1'b0;
          otg_retried_reg <= 1'b0;
          otg_cnt_reg <= 32'h0;
          boost_ok_reg <= 1'b0;
          boost_dtl_reg <= 4'h1;
          o_boost_fault_irq <= 1'b1;
        end else begin
          boost_ok_reg <= 1'b1;
          boost_dtl_reg <= 4'h0;
        end
      end else if (tick) begin
        otg_cnt_reg <= otg_cnt_reg + 32'h1;
        if (!otg_on_phase_reg && otg_cnt_reg + 32'h1 >= 32'(cfg6_reg[CFG6_LOWDUTY_BIT] ?
            OFF_LOW_US : (otg_retried_reg ? OFF_US : RETRY_US))) begin
          otg_on_phase_reg <= 1'b1;
          otg_cnt_reg <= 32'h0;
          o_outward_switch <= 1'b1;
        end else if (otg_on_phase_reg && otg_cnt_reg + 32'h1 >=
            32'(cfg6_reg[CFG6_LOWDUTY_BIT] ? ON_LOW_US : ON_US)) begin
          otg_cnt_reg <= 32'h0;
          otg_on_phase_reg <= 1'b0;
          otg_retried_reg <= 1'b1;
          o_outward_switch <= i_otg_overload ? 1'b0 : 1'b1;
          otg_latched_reg <= i_otg_overload;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] stag_cnt_reg;
  logic b_go;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !sec_enable) begin
      stag_cnt_reg <= 32'h0;
    end else if (stag_cnt_reg < 32'(STAGGER)) begin
      stag_cnt_reg <= stag_cnt_reg + 32'h1;
    end
  end
  assign b_go = stag_cnt_reg >= 32'(STAGGER);

  for (genvar g = 0; g < 2; g++) begin : g_line
    csplk_swi_t st_reg;
    logic [31:0] cnt_reg;
    logic [6:0] pulses_reg;
    logic [5:0] sent_reg;
    logic line_reg;
    logic go;
    assign go = g == 0 ? sec_enable : sec_enable && b_go;
    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        st_reg <= CSPLK_IDLE;
        cnt_reg <= 32'h0;
        pulses_reg <= 7'h0;
        sent_reg <= 6'h3f;
        line_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
        case (st_reg)
          CSPLK_IDLE: if (go) begin
            line_reg <= 1'b1;
            st_reg <= CSPLK_WAIT;
            cnt_reg <= 32'h0;
            sent_reg <= 6'h3f;
          end
          CSPLK_WAIT, CSPLK_STOP: begin
            if (!sec_enable) begin
              line_reg <= 1'b0;
              st_reg <= CSPLK_OFF;
              cnt_reg <= 32'h0;
            end else if (cnt_reg + 32'h1 >= 32'(st_reg == CSPLK_WAIT ? WAIT_CYC : STOP_CYC)
                && sec_cmd != sent_reg) begin
              pulses_reg <= 7'(sec_cmd) + 7'h1;
              sent_reg <= sec_cmd;
              line_reg <= 1'b0;
              st_reg <= CSPLK_LOW;
              cnt_reg <= 32'h0;
            end
          end
          CSPLK_LOW: if (cnt_reg + 32'h1 >= 32'(LOW_CYC)) begin
            line_reg <= 1'b1;
            pulses_reg <= pulses_reg - 7'h1;
            st_reg <= CSPLK_HIGH;
            cnt_reg <= 32'h0;
          end
          CSPLK_HIGH: if (pulses_reg == 7'h0) begin
            st_reg <= CSPLK_STOP;
            cnt_reg <= 32'h0;
          end else if (cnt_reg + 32'h1 >= 32'(HIGH_CYC)) begin
            line_reg <= 1'b0;
            st_reg <= CSPLK_LOW;
            cnt_reg <= 32'h0;
          end
          CSPLK_OFF: if (cnt_reg + 32'h1 >= 32'(OFF_CYC)) begin
            st_reg <= CSPLK_IDLE;
          end
          default: st_reg <= CSPLK_IDLE;
        endcase
      end
    end
  end
  assign o_pulse_line_a = g_line[0].line_reg;
  assign o_pulse_line_b = g_line[1].line_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sec_irq_reg <= 2'h0;
      o_sec_fault_irq <= 1'b0;
    end else begin
      sec_irq_reg <= i_sec_fault | ((i_rd && i_addr == ADDR_IRQ) ? 2'h0 : sec_irq_reg);
      o_sec_fault_irq <= |i_sec_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wd_reset_off_a: assert property ($rose(i_rst_n) |-> !wd_en_reg)
    else $error("watchdog enabled after reset");
  wd_stop_a: assert property ($rose(wd_expired_reg) |-> !o_charger_on ##1 !o_charger_on)
    else $error("charger on after expiry");
  wd_hold_a: assert property (wd_expired_reg && !wd_clear |=> wd_expired_reg)
    else $error("expiry left without clear");
  therm_irq_a: assert property ($rose(thermal_reg) |-> o_charger_irq && detail_reg == DTL_THERMAL)
    else $error("thermal entry not reported");
  therm_off_a: assert property (thermal_reg |=> !o_charger_on)
    else $error("charger on in shutdown");
  boost_mode_a: assert property (o_reverse_boost |-> $past(cfg0_reg[CFG0_CONV_BIT]))
    else $error("boost without converter bit");
  ovl_latch_a: assert property ($rose(o_boost_fault_irq) |-> !o_outward_switch && !boost_ok_reg)
    else $error("overload not latched");
  line_idle_a: assert property (!sec_enable ##1 !sec_enable [*8] |-> !o_pulse_line_a || $past(g_line[0].st_reg) != CSPLK_IDLE)
    else $error("line active while disabled");
  stagger_a: assert property ($rose(o_pulse_line_a) && g_line[0].st_reg == CSPLK_WAIT |-> !$rose(o_pulse_line_b))
    else $error("lines opened together");
  sec_irq_a: assert property (|i_sec_fault |=> o_sec_fault_irq)
    else $error("secondary fault not raised");
  cov_wd_c: cover property ($rose(wd_expired_reg));
  cov_therm_c: cover property ($rose(thermal_reg) ##[1:20] $fell(thermal_reg));
  cov_ovl_c: cover property ($rose(o_boost_fault_irq));
  cov_line_c: cover property ($rose(o_pulse_line_b));
endmodule // csplk_top

/* test/csplk_secondary.sv */
`timescale 1ns/1ps
module csplk_secondary import csplk_pkg::*; (
  input wire logic i_clock,
  input wire logic i_line,
  input wire logic i_fault_req,
  output logic o_on,
  output logic o_fault,
  output logic [5:0] o_value,
  output int o_cmds,
  output logic o_early
);
  int hi_cnt = 0;
  int lo_cnt = 0;
  int on_cnt = 0;
  int edges = 0;
  logic prev = 1'b0;
  initial begin
    o_on = 1'b0;
    o_value = 6'h00;
    o_cmds = 0;
    o_early = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // fault report back.
  assign o_fault = o_on & i_fault_req;
  always @(posedge i_clock) begin
    prev <= i_line;
    hi_cnt <= i_line ? hi_cnt + 1 : 0;
    lo_cnt <= i_line ? 0 : lo_cnt + 1;
    if (!o_on) begin
      if (i_line && !prev) begin
        o_on <= 1'b1;
        on_cnt <= 0;
        edges <= 0;
      end
    end else begin
      on_cnt <= on_cnt + 1;
      if (i_line && !prev) begin
        edges <= edges + 1;
        if (on_cnt < WAIT_CYC) o_early <= 1'b1;
      end
      if (hi_cnt == STOP_CYC - 20 && edges > 0) begin
        o_value <= 6'(edges - 1);
        o_cmds <= o_cmds + 1;
        edges <= 0;
      end
      if (lo_cnt == OFF_CYC - 20) o_on <= 1'b0;
    end
  end
endmodule // csplk_secondary

/* test/test_charger_supervisor_pulse_link.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); end end
module test_charger_supervisor_pulse_link import csplk_pkg::*;;
  logic i_clock, i_rst_n, i_wr, i_rd, i_temp_fault, i_otg_overload, i_sense_sel;
  logic [7:0] i_addr, i_wdata, o_rdata, rd_v;
  logic [2:0] i_chg_phase;
  logic [5:0] i_max_charge, pa_val, pb_val;
  wire [1:0] i_sec_fault;
  logic [1:0] fault_req;
  logic o_charger_on, o_charger_irq, o_boost_fault_irq, o_sec_fault_irq, o_reverse_boost;
  logic o_outward_switch, o_otg_current_limit_field_high, o_ext_sense, o_pulse_line_a, o_pulse_line_b;
  logic pa_on, pb_on, pa_early, pb_early;
  int pa_cmds, pb_cmds, want, n, t0, on_l, off_l;
  int error_cnt = 0;
  int checks = 0;
  int chg_irqs = 0;
  int bst_irqs = 0;
  int cyc = 0;
  wire [4:0] ev = {(pa_cmds == want) && (pb_cmds == want), o_sec_fault_irq, ~pa_on,
    o_pulse_line_b, o_pulse_line_a};
  csplk_top #(.WD_US(50), .ON_US(2), .OFF_US(4), .ON_LOW_US(2),
    .STAGGER(50)) u_csplk_top (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_chg_phase(i_chg_phase), .i_temp_fault(i_temp_fault), .i_otg_overload(i_otg_overload),
    .i_sense_sel(i_sense_sel), .i_max_charge(i_max_charge), .i_sec_fault(i_sec_fault),
    .o_charger_on(o_charger_on), .o_charger_irq(o_charger_irq),
    .o_boost_fault_irq(o_boost_fault_irq), .o_sec_fault_irq(o_sec_fault_irq),
    .o_reverse_boost(o_reverse_boost), .o_outward_switch(o_outward_switch),
    .o_otg_current_limit_field_high(o_otg_current_limit_field_high), .o_ext_sense(o_ext_sense),
    .o_pulse_line_a(o_pulse_line_a), .o_pulse_line_b(o_pulse_line_b));
  csplk_secondary u_csplk_secondary_a (.i_clock(i_clock), .i_line(o_pulse_line_a),
    .i_fault_req(fault_req[0]), .o_on(pa_on), .o_fault(i_sec_fault[0]), .o_value(pa_val),
    .o_cmds(pa_cmds), .o_early(pa_early));
  csplk_secondary u_csplk_secondary_b (.i_clock(i_clock), .i_line(o_pulse_line_b),
    .i_fault_req(fault_req[1]), .o_on(pb_on), .o_fault(i_sec_fault[1]), .o_value(pb_val),
    .o_cmds(pb_cmds), .o_early(pb_early));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string nm);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
    `CHK(nm, e, rd_v & m)
  endtask
  task automatic wait_ev(input int idx, input int lim);
    int k;
    k = 0;
    while (ev[idx] !== 1'b1 && k < lim) begin
      idle(1);
      k++;
    end
    `CHK("event", 1'b1, ev[idx])
  endtask
  task automatic run_len(input logic lvl, output int len);
    len = 0;
    while (o_outward_switch === lvl && len < 5000) begin
      idle(1);
      len++;
    end
  endtask
  function automatic logic near(input int v, input int e);
    return (v >= e - 110) && (v <= e + 110);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_charger_irq === 1'b1) chg_irqs++;
    if (o_boost_fault_irq === 1'b1) bst_irqs++;
    if (cyc == 98000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_temp_fault, i_otg_overload, i_sense_sel} = 6'h00;
    {i_addr, i_wdata, i_chg_phase, i_max_charge, fault_req, want} = '0;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    idle(2);
    rchk(ADDR_CFG0, 8'hff, CFG0_RST, "cfg0");
    rchk(ADDR_CFG6, 8'hff, CFG6_RST, "cfg6");
    rchk(ADDR_WDCTL, 8'h81, 8'h00, "wd_rst");
    wr(8'h55, 8'hff);
    rchk(8'h55, 8'hff, 8'h00, "unmapped");
    rchk(ADDR_CFG0, 8'hff, 8'h00, "cfg0_kept");
    @(posedge i_clock) i_chg_phase <= 3'd1;
    idle(6000);
    `CHK("on_nowd", 1'b1, o_charger_on)
    wr(ADDR_WDCTL, 8'h80);
    rchk(ADDR_WDCTL, 8'h81, 8'h80, "wd_en");
    idle(4000);
    wr(ADDR_WDCTL, 8'h81);
    idle(4000);
    `CHK("on_served", 1'b1, o_charger_on)
    n = chg_irqs;
    idle(1500);
    `CHK("on_expired", 1'b0, o_charger_on)
    `CHK("irq_wd", n + 1, chg_irqs)
    rchk(ADDR_STAT, 8'h8f, {4'h0, DTL_WATCHDOG}, "stat_wd");
    rchk(ADDR_WDCTL, 8'h01, 8'h01, "wd_flag");
    idle(2000);
    `CHK("on_held", 1'b0, o_charger_on)
    wr(ADDR_WDCTL, 8'h81);
    idle(3);
    `CHK("on_restart", 1'b1, o_charger_on)
    wr(ADDR_WDCTL, 8'h00);
    n = chg_irqs;
    @(posedge i_clock) i_temp_fault <= 1'b1;
    idle(4);
    `CHK("on_hot", 1'b0, o_charger_on)
    `CHK("irq_hot", n + 1, chg_irqs)
    rchk(ADDR_STAT, 8'hbf, {4'h2, DTL_THERMAL}, "stat_hot");
    @(posedge i_clock) i_temp_fault <= 1'b0;
    idle(4);
    `CHK("on_cool", 1'b1, o_charger_on)
    rchk(ADDR_STAT, 8'h20, 8'h00, "stat_cool");
    for (int m = 9; m <= 10; m++) begin
      wr(ADDR_CFG0, 8'h80 | 8'(m));
      idle(3);
      `CHK("rev", 1'b1, o_reverse_boost)
      `CHK("sw", 1'b1, o_outward_switch)
    end
    wr(ADDR_CFG0, 8'h09);
    idle(3);
    `CHK("rev_nobit", 1'b0, o_reverse_boost)
    wr(ADDR_CFG6, 8'h02);
    idle(3);
    `CHK("ilim_hi", 1'b1, o_otg_current_limit_field_high)
    wr(ADDR_CFG6, 8'h00);
    wr(ADDR_CFG0, 8'h8a);
    idle(3);
    `CHK("ilim_lo", 1'b0, o_otg_current_limit_field_high)
    n = bst_irqs;
    @(posedge i_clock) i_otg_overload <= 1'b1;
    idle(4);
    t0 = cyc;
    `CHK("irq_bst", n + 1, bst_irqs)
    `CHK("sw_latch", 1'b0, o_outward_switch)
    rchk(ADDR_STAT, 8'h40, 8'h00, "boost_ok");
    rchk(ADDR_IRQ, 8'h01, 8'h01, "boost_dtl");
    run_len(1'b0, n);
    `CHK("retry", 1'b1, near(cyc - t0, 600))
    run_len(1'b1, on_l);
    run_len(1'b0, off_l);
    `CHK("on_len", 1'b1, near(on_l, 200))
    `CHK("off_len", 1'b1, near(off_l, 400))
    wr(ADDR_CFG6, 8'h20);
    run_len(o_outward_switch, n);
    if (o_outward_switch === 1'b1) run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, on_l);
    run_len(1'b0, off_l);
    `CHK("on_low", 1'b1, near(on_l, 200))
    `CHK("off_low", 1'b1, near(off_l, 100))
    @(posedge i_clock) i_otg_overload <= 1'b0;
    wr(ADDR_CFG0, 8'h00);
    wr(ADDR_CFG6, 8'h00);
    @(posedge i_clock) i_sense_sel <= 1'b1;
    idle(3);
    `CHK("ext_sense", 1'b1, o_ext_sense)
    `CHK("line_idle", 1'b0, o_pulse_line_a)
    wr(ADDR_SEC, 8'h0c);
    want = 1;
    @(posedge i_clock) i_max_charge <= 6'h05;
    @(posedge i_clock) i_chg_phase <= 3'd2;
    wait_ev(0, 20);
    t0 = cyc;
    wait_ev(1, 400);
    `CHK("stagger", 1'b1, cyc - t0 >= 50)
    wait_ev(4, 40000);
    `CHK("val_a_min", 6'h05, pa_val)
    `CHK("val_b_min", 6'h05, pb_val)
    `CHK("early", 2'b00, {pa_early, pb_early})
    `CHK("stop_high", 1'b1, o_pulse_line_a)
    @(posedge i_clock) fault_req <= 2'b01;
    wait_ev(3, 10);
    rchk(ADDR_IRQ, 8'h30, 8'h10, "sec_flt");
    @(posedge i_clock) fault_req <= 2'b00;
    idle(3);
    `CHK("sec_irq_off", 1'b0, o_sec_fault_irq)
    rchk(ADDR_IRQ, 8'h30, 8'h10, "sec_sticky");
    rchk(ADDR_IRQ, 8'h30, 8'h00, "sec_clr");
    @(posedge i_clock) i_chg_phase <= 3'd5;
    wait_ev(2, 21000);
    `CHK("line_off", 1'b0, o_pulse_line_a)
    wr(ADDR_SEC, 8'h8c);
    want = 2;
    @(posedge i_clock) i_chg_phase <= 3'd3;
    wait_ev(4, 40000);
    `CHK("val_a_raw", 6'h0c, pa_val)
    `CHK("val_b_raw", 6'h0c, pb_val)
    print_verdict();
  end
endmodule // test_charger_supervisor_pulse_link
